// File: src/ptm_timer.v
// periodic timer: apb registers, counter, compare, capture and output pin
`timescale 1ns/1ps
`default_nettype none
`include "ptm_consts.vh"
module ptm_timer #(
    parameter CW = 10
) (
    // clock and reset
    input wire clk_i,
    input wire nrst_i,
    // apb slave
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [3:0] pstrb_i,
    output wire pready_o,
    output reg [31:0] prdata_o,
    output wire pslverr_o,
    // internal clock enables, one-cycle pulses
    input wire high_clock_div16_i,
    input wire high_clock_div64_i,
    input wire sub_clock_tick_i,
    // pins
    input wire ext_clock_pin_i,
    input wire capture_input_pin_i,
    output reg timer_output_pin_o,
    output wire timer_output_pin_n_o,
    output wire timer_output_en_o,
    // status
    output wire compare_a_hit_o,
    output wire period_hit_o,
    output wire capture_hit_o
);
    ////////////////////////////////////////////////////////////////
    reg [7:0] ctrl_a;
    reg [7:0] ctrl_b;
    reg [CW-1:0] count;
    reg [CW-1:0] cmp_a;
    reg [CW-1:0] period;
    reg [1:0] div4;
    reg [2:0] ck_sync;
    reg [2:0] cap_sync;
    reg run_d;
    reg out_q;
    reg a_hit;
    reg p_hit;
    reg c_hit;
    wire run = ctrl_a[`PTM_A_RUN];
    wire pause = ctrl_a[`PTM_A_PAUSE];
    wire [2:0] cksel = ctrl_a[`PTM_A_CKSEL_HI:`PTM_A_CKSEL_LO];
    wire [1:0] mode = ctrl_b[`PTM_B_MODE_HI:`PTM_B_MODE_LO];
    wire [1:0] pinf = ctrl_b[`PTM_B_PINF_HI:`PTM_B_PINF_LO];
    wire init_lvl = ctrl_b[`PTM_B_INIT];
    wire inv = ctrl_b[`PTM_B_INV];
    wire capsrc = ctrl_b[`PTM_B_CAPSRC];
    wire clrsrc = ctrl_b[`PTM_B_CLRSRC];
    wire run_rise = run & ~run_d;

    ////////////////////////////////////////////////////////////////
    // apb decode, zero wait states
    wire wr = psel_i & penable_i & pwrite_i & pstrb_i[0];
    wire acc = psel_i & penable_i;
    reg mapped;
    assign pready_o = 1'b1;
    assign pslverr_o = acc & ~mapped;

    // read mux and map check
    always @*
    begin
        mapped = 1'b1;
        prdata_o = 32'h0000_0000;
        case (paddr_i)
            `PTM_OFS_CTRL_A: prdata_o[7:0] = {ctrl_a[7:3], 3'b000};
            `PTM_OFS_CTRL_B: prdata_o[7:0] = ctrl_b;
            `PTM_OFS_CNT_LO: prdata_o[7:0] = count[7:0];
            `PTM_OFS_CNT_HI: prdata_o[1:0] = count[CW-1:8];
            `PTM_OFS_CMPA_LO: prdata_o[7:0] = cmp_a[7:0];
            `PTM_OFS_CMPA_HI: prdata_o[1:0] = cmp_a[CW-1:8];
            `PTM_OFS_PER_LO: prdata_o[7:0] = period[7:0];
            `PTM_OFS_PER_HI: prdata_o[1:0] = period[CW-1:8];
            default: mapped = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // pin synchronisers, two flops before use
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ck_sync <= 3'b000;
            cap_sync <= 3'b000;
        end
        else
        begin
            ck_sync <= {ck_sync[1:0], ext_clock_pin_i};
            cap_sync <= {cap_sync[1:0], capture_input_pin_i};
        end
    end
    wire ck_rise = ck_sync[1] & ~ck_sync[2];
    wire ck_fall = ~ck_sync[1] & ck_sync[2];

    // clock source select
    reg tick;
    always @*
    begin
        case (cksel)
            `PTM_CK_SYS4: tick = (div4 == `PTM_DIV4);
            `PTM_CK_SYS: tick = 1'b1;
            `PTM_CK_H16: tick = high_clock_div16_i;
            `PTM_CK_H64: tick = high_clock_div64_i;
            `PTM_CK_SUB0, `PTM_CK_SUB1: tick = sub_clock_tick_i;
            `PTM_CK_EXTR: tick = ck_rise;
            `PTM_CK_EXTF: tick = ck_fall;
            default: tick = 1'b0;
        endcase
    end

    // capture trigger select
    wire cap_r = capsrc ? ck_sync[1] : cap_sync[1];
    wire cap_p = capsrc ? ck_sync[2] : cap_sync[2];
    reg cap_evt;
    always @*
    begin
        case (pinf)
            2'b00: cap_evt = cap_r & ~cap_p;
            2'b01: cap_evt = ~cap_r & cap_p;
            2'b10: cap_evt = cap_r ^ cap_p;
            default: cap_evt = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // compare and clear decisions
    wire counting = run & ~pause & tick & ~run_rise;
    wire a_match = counting & (count == cmp_a);
    wire p_match = counting & (count == period - 10'h001);
    wire ovf = counting & (count == `PTM_CNT_MAX);
    wire single = (mode == `PTM_MODE_PWM) & (pinf == 2'b11);
    reg clr;
    always @*
    begin
        if (mode == `PTM_MODE_CMP || mode == `PTM_MODE_TMR)
            clr = clrsrc ? a_match : (p_match | (ovf & (period == 10'h000)));
        else if (single)
            clr = 1'b0;
        else
            clr = p_match | (ovf & (period == 10'h000));
    end

    // registers, counter and pulse end
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ctrl_a <= `PTM_RST_BYTE;
            ctrl_b <= `PTM_RST_BYTE;
            cmp_a <= `PTM_RST_CNT;
            period <= `PTM_RST_CNT;
            count <= `PTM_RST_CNT;
            div4 <= 2'h0;
            run_d <= 1'b0;
            a_hit <= 1'b0;
            p_hit <= 1'b0;
            c_hit <= 1'b0;
        end
        else
        begin
            run_d <= run;
            div4 <= div4 + 2'h1;
            a_hit <= a_match;
            p_hit <= p_match & ~(clrsrc & (mode == `PTM_MODE_CMP || mode == `PTM_MODE_TMR));
            c_hit <= 1'b0;
            if (wr && paddr_i == `PTM_OFS_CTRL_A)
                ctrl_a <= {pwdata_i[7:3], 3'b000};
            else if (single && run && a_match)
                ctrl_a[`PTM_A_RUN] <= 1'b0; // pulse ends on compare A
            else if (single && !run && ck_rise)
                ctrl_a[`PTM_A_RUN] <= 1'b1; // pin starts the pulse
            if (wr && paddr_i == `PTM_OFS_CTRL_B)
                ctrl_b <= pwdata_i[7:0];
            if (wr && paddr_i == `PTM_OFS_CMPA_LO)
                cmp_a[7:0] <= pwdata_i[7:0];
            if (wr && paddr_i == `PTM_OFS_CMPA_HI)
                cmp_a[CW-1:8] <= pwdata_i[1:0];
            if (wr && paddr_i == `PTM_OFS_PER_LO)
                period[7:0] <= pwdata_i[7:0];
            if (wr && paddr_i == `PTM_OFS_PER_HI)
                period[CW-1:8] <= pwdata_i[1:0];
            if (run_rise)
                count <= `PTM_RST_CNT;
            else if (clr)
                count <= `PTM_RST_CNT;
            else if (counting)
                count <= count + 10'h001;
            if (mode == `PTM_MODE_CAP && run && cap_evt)
            begin
                cmp_a <= count; // captured value into compare A
                c_hit <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // output level logic before polarity
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            out_q <= 1'b0;
        else if (run_rise)
            out_q <= init_lvl;
        else if (mode == `PTM_MODE_CMP && a_match)
        begin
            case (pinf)
                2'b01: out_q <= 1'b0;
                2'b10: out_q <= 1'b1;
                2'b11: out_q <= ~out_q;
                default: out_q <= out_q;
            endcase
        end
        else if (single && run && a_match)
            out_q <= ~init_lvl;
    end

    // pwm active while count below duty, full duty when duty >= period
    wire pwm_act = (count < cmp_a);
    reg lvl;
    always @*
    begin
        lvl = out_q;
        if (mode == `PTM_MODE_PWM)
        begin
            case (pinf)
                2'b00: lvl = ~init_lvl;
                2'b01: lvl = init_lvl;
                2'b10: lvl = pwm_act ? init_lvl : ~init_lvl;
                default: lvl = out_q;
            endcase
        end
    end

    // registered pin with invert, idle in timer and capture modes
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            timer_output_pin_o <= 1'b0;
        else if (mode == `PTM_MODE_TMR || mode == `PTM_MODE_CAP)
            timer_output_pin_o <= 1'b0;
        else
            timer_output_pin_o <= lvl ^ inv;
    end
    assign timer_output_pin_n_o = ~timer_output_pin_o;
    assign timer_output_en_o = (mode == `PTM_MODE_CMP) | (mode == `PTM_MODE_PWM);
    assign compare_a_hit_o = a_hit;
    assign period_hit_o = p_hit;
    assign capture_hit_o = c_hit;
endmodule
`default_nettype wire

// File: src/ptm_consts.vh
// constants for the periodic timer register block
// Behaviour
// - three-bit field picks counter clock source
// - run rising edge zeroes the counter
// - run low stops counter, value kept
// - run rising edge restores output initial level
// - two-bit field selects operating mode
// - timer/counter mode ignores output level bits
// - compare A match sets, clears, toggles output
// - match to same level shows no change
// - PWM field: inactive, active, PWM, single pulse
// - capture edge: rising, falling, both, disabled
// - capture source: capture pin or clock pin
// - initial level bit sets compare-mode level
// - initial level sets PWM active level
// - invert bit inverts timer output pin; pin held low in timer and capture modes
// - clear source: compare A, or period/overflow
// - overflow clear only when period is zero
// - clear source ignored in PWM, pulse, capture
// - counter readable only, high bits zero
// - compare A and period registers reset zero
// - pause freezes counter, resume continues
// - period zero gives 1024 counts
`ifndef PTM_CONSTS_VH
`define PTM_CONSTS_VH
`define PTM_OFS_CTRL_A 12'h000
`define PTM_OFS_CTRL_B 12'h004
`define PTM_OFS_CNT_LO 12'h008
`define PTM_OFS_CNT_HI 12'h00c
`define PTM_OFS_CMPA_LO 12'h010
`define PTM_OFS_CMPA_HI 12'h014
`define PTM_OFS_PER_LO 12'h018
`define PTM_OFS_PER_HI 12'h01c
`define PTM_RST_BYTE 8'h00
`define PTM_RST_CNT 10'h000
`define PTM_CNT_MAX 10'h3ff
`define PTM_A_PAUSE 7
`define PTM_A_CKSEL_HI 6
`define PTM_A_CKSEL_LO 4
`define PTM_A_RUN 3
`define PTM_B_MODE_HI 7
`define PTM_B_MODE_LO 6
`define PTM_B_PINF_HI 5
`define PTM_B_PINF_LO 4
`define PTM_B_INIT 3
`define PTM_B_INV 2
`define PTM_B_CAPSRC 1
`define PTM_B_CLRSRC 0
`define PTM_MODE_CMP 2'b00
`define PTM_MODE_CAP 2'b01
`define PTM_MODE_PWM 2'b10
`define PTM_MODE_TMR 2'b11
`define PTM_CK_SYS4 3'h0
`define PTM_CK_SYS 3'h1
`define PTM_CK_H16 3'h2
`define PTM_CK_H64 3'h3
`define PTM_CK_SUB0 3'h4
`define PTM_CK_SUB1 3'h5
`define PTM_CK_EXTR 3'h6
`define PTM_CK_EXTF 3'h7
`define PTM_DIV4 2'h3
`endif

// File: testbench/ptm_sva.sv
// port assertions for the periodic timer
`timescale 1ns/1ps
`default_nettype none
`include "ptm_consts.vh"
module ptm_sva (
    // watched ports
    input wire clk_i,
    input wire nrst_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [3:0] pstrb_i,
    input wire pready_o,
    input wire [31:0] prdata_o,
    input wire pslverr_o,
    input wire timer_output_pin_o,
    input wire timer_output_pin_n_o,
    input wire timer_output_en_o
);
    wire acc = psel_i & penable_i;
    wire rd = acc & ~pwrite_i;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);
    a_ready_high: assert property (psel_i |-> pready_o) else $error("pready low");
    a_err_unmapped: assert property (acc && paddr_i >= 12'h020 |-> pslverr_o && (pwrite_i || prdata_o == 0))
        else $error("unmapped access not refused");
    a_err_mapped: assert property (acc && paddr_i == `PTM_OFS_PER_HI |-> !pslverr_o) else $error("mapped refused");
    a_pin_pair: assert property (timer_output_pin_n_o == !timer_output_pin_o) else $error("pin pair");
    a_cnt_hi_zero: assert property (rd && paddr_i == `PTM_OFS_CNT_HI |-> prdata_o[31:2] == 0)
        else $error("count high bits");
    a_ctrla_unused: assert property (rd && paddr_i == `PTM_OFS_CTRL_A |-> prdata_o[2:0] == 0)
        else $error("control low bits");
    a_hi_bytes: assert property (rd && paddr_i[4:0] inside {5'h14, 5'h1c} |-> prdata_o[31:2] == 0)
        else $error("value high bits");
    a_en_mode: assert property (acc && pwrite_i && pstrb_i[0] && paddr_i == `PTM_OFS_CTRL_B
        |=> timer_output_en_o == !$past(pwdata_i[6])) else $error("pin enable by mode");
endmodule
bind ptm_timer ptm_sva u_sva (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .pready_o(pready_o),
    .prdata_o(prdata_o), .pslverr_o(pslverr_o), .timer_output_pin_o(timer_output_pin_o),
    .timer_output_pin_n_o(timer_output_pin_n_o), .timer_output_en_o(timer_output_en_o));
`default_nettype wire

// File: testbench/ptm_pins.sv
// outside world: clock enables and the two input pins
`timescale 1ns/1ps
`default_nettype none
module ptm_pins (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // driven lines
    output logic ext_o = 1'b0,
    output logic cap_o = 1'b0,
    output wire logic d16_o,
    output wire logic d64_o,
    output wire logic sub_o
);
    logic [7:0] div;
    // free-running divider for the internal clock enables
    always @(posedge clk_i or negedge nrst_i)
        if (!nrst_i)
            div <= 8'h00;
        else
            div <= div + 8'h01;
    assign d16_o = div[3:0] == 4'hf;
    assign d64_o = div[5:0] == 6'h3f;
    assign sub_o = div[4:0] == 5'h1f;
    // whole pin cycles, each level held past the synchroniser
    task automatic pulses(input int n);
        repeat (n)
        begin
            repeat (4) @(posedge clk_i);
            ext_o <= 1'b1;
            cap_o <= ~cap_o;
            repeat (4) @(posedge clk_i);
            ext_o <= 1'b0;
        end
        repeat (6) @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

// File: testbench/tb.sv
// self-checking bench for the periodic timer
`timescale 1ns/1ps
`default_nettype none
`include "ptm_consts.vh"
module tb;
    logic clk_i = 0, nrst_i = 0, psel = 0, pen = 0, pwr = 0, i0, v0;
    logic [11:0] addr = 0;
    logic [31:0] wdata = 0;
    logic [7:0] r, e;
    logic er;
    wire [31:0] prdata;
    wire pready, perr, pin, ext, cap, d16, d64, sub, pin_en;
    int n_mismatch = 0, cmp_count = 0, seed = 9, n;
    always #4 clk_i = ~clk_i;
    ptm_timer dut (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
        .paddr_i(addr), .pwdata_i(wdata), .pstrb_i(4'hf), .pready_o(pready), .prdata_o(prdata),
        .pslverr_o(perr), .high_clock_div16_i(d16), .high_clock_div64_i(d64), .sub_clock_tick_i(sub),
        .ext_clock_pin_i(ext), .capture_input_pin_i(cap), .timer_output_pin_o(pin),
        .timer_output_pin_n_o(), .timer_output_en_o(pin_en), .compare_a_hit_o(), .period_hit_o(),
        .capture_hit_o());
    ptm_pins pins (.clk_i(clk_i), .nrst_i(nrst_i), .ext_o(ext), .cap_o(cap), .d16_o(d16), .d64_o(d64),
        .sub_o(sub));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one apb transfer, read byte left in r
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int t = 0;
        psel <= 1'b1;
        pwr <= w;
        addr <= a;
        wdata <= {24'h0, d};
        @(posedge clk_i);
        pen <= 1'b1;
        do
        begin
            @(posedge clk_i);
            t++;
        end while (pready !== 1'b1 && t < 20);
        if (t >= 20)
            n_mismatch++;
        r = prdata[7:0];
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] x);
        apb(1'b0, a, 8'h00);
        check($sformatf("reg %h", a), r, x);
    endtask
    function automatic logic exp_pin(input int k, input logic i);
        return k == 0 ? i : k == 1 ? 1'b0 : k == 2 ? 1'b1 : ~i;
    endfunction
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        #400000;
        n_mismatch++;
        tally_and_finish;
    end
    initial
    begin
        repeat (10) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        for (int k = 0; k < 8; k++)
            rd(12'(k * 4), 8'h00);
        apb(1'b1, `PTM_OFS_CNT_LO, 8'hff);
        rd(`PTM_OFS_CNT_LO, 8'h00);
        apb(1'b0, 12'h020, 8'h00);
        check("unmapped error", er, 1'b1);
        check("unmapped data", r, 8'h00);
        for (int k = 4; k < 8; k++)
        begin
            e = 8'($random(seed));
            apb(1'b1, 12'(k * 4), e);
            rd(12'(k * 4), k[0] ? e & 8'h03 : e);
        end
        $display("registers done");
        for (int k = 0; k < 4; k++)
        begin
            apb(1'b1, 12'(k * 4 + 16), 8'h00);
            apb(1'b1, `PTM_OFS_CTRL_B, {2'(k), 6'h00});
            check("pin enable", pin_en, k[0] == 0);
        end
        apb(1'b1, `PTM_OFS_CTRL_B, 8'h00);
        for (int k = 0; k < 4; k++)
        begin
            n = 2 + ($random(seed) & 7);
            apb(1'b1, `PTM_OFS_CTRL_A, {1'b0, 2'b11, k[0], 4'h0});
            apb(1'b1, `PTM_OFS_CTRL_A, {k[1], 2'b11, k[0], 4'h8});
            pins.pulses(n);
            apb(1'b1, `PTM_OFS_CTRL_A, {1'b0, 2'b11, k[0], 4'h0});
            pins.pulses(2);
            rd(`PTM_OFS_CNT_LO, k[1] ? 8'h00 : 8'(n));
        end
        apb(1'b1, `PTM_OFS_PER_LO, 8'h04);
        apb(1'b1, `PTM_OFS_CTRL_A, 8'h68);
        pins.pulses(6);
        rd(`PTM_OFS_CNT_LO, 8'h02);
        $display("counting done");
        // period back to zero so the six internal sources (select 0 to 5) can count freely
        apb(1'b1, `PTM_OFS_PER_LO, 8'h00);
        for (int k = 0; k < 6; k++)
        begin
            apb(1'b1, `PTM_OFS_CTRL_A, {1'b0, 3'(k), 4'h8});
            repeat (200) @(posedge clk_i);
            apb(1'b1, `PTM_OFS_CTRL_A, {1'b0, 3'(k), 4'h0});
            apb(1'b0, `PTM_OFS_CNT_LO, 8'h00);
            check("count moved", r != 8'h00, 1'b1);
        end
        $display("clock sources done");
        apb(1'b1, `PTM_OFS_CMPA_LO, 8'h02);
        for (int k = 0; k < 4; k++)
        begin
            i0 = 1'($random(seed));
            v0 = 1'($random(seed));
            apb(1'b1, `PTM_OFS_CTRL_A, 8'h60);
            apb(1'b1, `PTM_OFS_CTRL_B, {2'b00, 2'(k), i0, v0, 2'b00});
            apb(1'b1, `PTM_OFS_CTRL_A, 8'h68);
            repeat (3) @(posedge clk_i);
            check("pin at start", pin, i0 ^ v0);
            pins.pulses(3);
            check("pin after match", pin, exp_pin(k, i0) ^ v0);
        end
        $display("output pin done");
        // pwm mode forced levels, set while stopped
        apb(1'b1, `PTM_OFS_CTRL_A, 8'h60);
        apb(1'b1, `PTM_OFS_CTRL_B, 8'h98);
        repeat (3) @(posedge clk_i);
        check("pwm forced active", pin, 1'b1);
        apb(1'b1, `PTM_OFS_CTRL_B, 8'h88);
        repeat (3) @(posedge clk_i);
        check("pwm forced inactive", pin, 1'b0);
        $display("pwm levels done");
        tally_and_finish;
    end
endmodule
`default_nettype wire
